// [src/vmfc_top.sv]
module vmfc_top #(
  parameter int US_CYCLES = vmfc_pkg::US_CYCLES
) (
  input wire logic MCLK, // 100 MHz clock
  input wire logic SRST, // synchronous reset, high
  input wire logic [7:0] NODE_ID, // own node id for PWM
  input wire logic TX_HDR_VALID, // record header offered
  output logic TX_HDR_READY, // header taken
  input wire logic [31:0] TX_PROTOCOL, // protocol selector
  input wire logic [31:0] TX_FLAGS, // transmit flag word
  input wire logic [31:0] TX_COUNT, // record byte count
  input wire logic TX_BYTE_VALID, // record byte offered
  output logic TX_BYTE_READY, // record byte taken
  input wire logic [7:0] TX_BYTE, // record byte
  output logic TX_DONE, // record finished, pulse
  output logic TX_ERROR, // malformed record error, with done
  output logic NET_TX_VALID, // network byte valid
  input wire logic NET_TX_READY, // network accepts byte
  output logic [7:0] NET_TX_DATA, // network byte
  output logic NET_TX_LAST, // last byte of frame
  output logic NET_TX_LONG_ID, // 29-bit identifier
  input wire logic NET_FC_CTS, // flow control clear to send
  input wire logic [31:0] RX_PROTOCOL, // receive protocol selector
  input wire logic RX_EXT_ADDR, // receive extended addressing
  input wire logic NET_RX_VALID, // received byte valid
  input wire logic [7:0] NET_RX_DATA, // received byte
  input wire logic NET_RX_LAST, // last received byte of frame
  input wire logic NET_RX_TRAILER, // byte is IFR, CRC or checksum
  input wire logic NET_RX_LONG_ID, // frame had 29-bit id
  output logic REC_VALID, // record byte valid
  output logic [7:0] REC_DATA, // record byte
  output logic REC_DONE, // record complete, pulse
  output logic [12:0] REC_COUNT, // record byte count
  output logic [12:0] REC_TRAILER_IDX, // trailer start index
  output logic [31:0] REC_TIMESTAMP, // reception time, us
  output logic [31:0] REC_STATUS // receive status word
);
  if (US_CYCLES < 1) begin : g_chk
    $error("US_CYCLES must be at least 1");
  end

  typedef enum {S_IDLE, S_PASS, S_PWM_HOLD, S_PWM_SEND, S_DRAIN,
                S_TP_ID, S_TP_FRAME, S_TP_WAIT, S_REPORT} vmfc_st_t;
  typedef enum {F_ID, F_EXT, F_PCI0, F_PCI1, F_DATA, F_PAD} vmfc_fld_t;

  vmfc_st_t st_q;
  vmfc_fld_t fld_q;
  logic [31:0] proto_q;
  logic [12:0] cnt_q, idx_q, pay_q, sent_q, hlast;
  logic [7:0] hold_q [3];
  logic [7:0] idb_q [5];
  logic [1:0] rep_q, ib_q;
  logic [3:0] pos_q, sn_q;
  logic err_q, ext_q, pad_q, first_q, single_q, long_q;
  logic hdr_ok, in_x, out_x, last_in, f_end, data_end, all_sent;
  logic [7:0] pci0;

  vmfc_time_if tm_if ();

  vmfc_ustimer #(.CYCLES(US_CYCLES)) u_timer (
    .clk(MCLK),
    .rst(SRST),
    .tm(tm_if)
  );

  vmfc_rx u_rx (
    .clk(MCLK),
    .rst(SRST),
    .proto(RX_PROTOCOL),
    .ext_addr(RX_EXT_ADDR),
    .in_v(NET_RX_VALID),
    .in_d(NET_RX_DATA),
    .in_last(NET_RX_LAST),
    .in_trl(NET_RX_TRAILER),
    .in_long(NET_RX_LONG_ID),
    .tm(tm_if),
    .out_v(REC_VALID),
    .out_d(REC_DATA),
    .done(REC_DONE),
    .count(REC_COUNT),
    .trl_idx(REC_TRAILER_IDX),
    .stamp(REC_TIMESTAMP),
    .status(REC_STATUS)
  );

  // header check on the offered record
  assign hdr_ok = vmfc_pkg::len_ok(TX_PROTOCOL, TX_COUNT);
  assign in_x = TX_BYTE_VALID && TX_BYTE_READY;
  assign out_x = NET_TX_VALID && NET_TX_READY;
  assign last_in = idx_q == cnt_q - 13'h1;
  assign hlast = ext_q ? vmfc_pkg::ID_EXT_LAST : vmfc_pkg::ID_LAST;
  assign data_end = pos_q == vmfc_pkg::CAN_LAST_POS || sent_q + 13'h1 == pay_q;
  assign all_sent = fld_q == F_DATA ? sent_q + 13'h1 == pay_q : sent_q == pay_q;
  assign TX_HDR_READY = st_q == S_IDLE;
  assign TX_DONE = st_q == S_REPORT;
  assign TX_ERROR = st_q == S_REPORT && err_q;
  assign NET_TX_LONG_ID = long_q;

  // segmentation control byte for the current frame
  always_comb begin
    if (single_q)
      pci0 = {vmfc_pkg::PCI_SF, pay_q[3:0]};
    else if (first_q)
      pci0 = {vmfc_pkg::PCI_FF, pay_q[11:8]}; // 4096-byte payload does not fit 12 bits
    else
      pci0 = {vmfc_pkg::PCI_CF, sn_q};
  end

  // network byte selection and frame end
  always_comb begin
    NET_TX_VALID = 1'b0;
    NET_TX_DATA = 8'h00;
    f_end = 1'b0;
    TX_BYTE_READY = 1'b0;
    case (st_q)
      S_PASS: begin
        NET_TX_VALID = TX_BYTE_VALID;
        NET_TX_DATA = TX_BYTE;
        TX_BYTE_READY = NET_TX_READY;
        f_end = last_in;
      end
      S_PWM_HOLD, S_DRAIN, S_TP_ID: TX_BYTE_READY = 1'b1;
      S_PWM_SEND: begin
        NET_TX_VALID = 1'b1;
        NET_TX_DATA = hold_q[rep_q];
        f_end = rep_q == 2'h2 && cnt_q == vmfc_pkg::PWM_HDR;
      end
      S_TP_FRAME: begin
        NET_TX_VALID = fld_q != F_DATA || TX_BYTE_VALID;
        case (fld_q)
          F_ID: NET_TX_DATA = idb_q[ib_q];
          F_EXT: NET_TX_DATA = idb_q[4];
          F_PCI0: begin
            NET_TX_DATA = pci0;
            f_end = (single_q || !first_q) && sent_q == pay_q && !pad_q;
          end
          F_PCI1: NET_TX_DATA = pay_q[7:0];
          F_DATA: begin
            NET_TX_DATA = TX_BYTE;
            TX_BYTE_READY = NET_TX_READY;
            f_end = data_end && !(pad_q && pos_q != vmfc_pkg::CAN_LAST_POS);
          end
          F_PAD: f_end = pos_q == vmfc_pkg::CAN_LAST_POS;
          default: NET_TX_DATA = 8'h00;
        endcase
      end
      default: NET_TX_VALID = 1'b0;
    endcase
  end
  assign NET_TX_LAST = f_end;

  // record sequencer
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      st_q <= S_IDLE;
      fld_q <= F_ID;
    end else begin
      case (st_q)
        S_IDLE: if (TX_HDR_VALID) begin
          if (!hdr_ok || TX_COUNT == 32'h0)
            st_q <= S_REPORT;
          else if (TX_PROTOCOL == vmfc_pkg::PROTO_PWM)
            st_q <= S_PWM_HOLD;
          else if (TX_PROTOCOL == vmfc_pkg::PROTO_ISOTP)
            st_q <= S_TP_ID;
          else
            st_q <= S_PASS;
        end
        S_PASS, S_DRAIN: if (in_x && last_in)
          st_q <= S_REPORT;
        S_PWM_HOLD: if (in_x && idx_q == vmfc_pkg::PWM_SRC_POS) begin
          if (TX_BYTE != NODE_ID)
            st_q <= cnt_q == vmfc_pkg::PWM_HDR ? S_REPORT : S_DRAIN;
          else
            st_q <= S_PWM_SEND;
        end
        S_PWM_SEND: if (out_x && rep_q == 2'h2)
          st_q <= cnt_q == vmfc_pkg::PWM_HDR ? S_REPORT : S_PASS;
        S_TP_ID: if (in_x && idx_q == hlast) begin
          st_q <= S_TP_FRAME;
          fld_q <= F_ID;
        end
        S_TP_FRAME: if (out_x) begin
          if (f_end) begin
            fld_q <= F_ID;
            if (all_sent)
              st_q <= S_REPORT;
            else if (first_q)
              st_q <= S_TP_WAIT;
          end else begin
            case (fld_q)
              F_ID: if (ib_q == 2'h3)
                fld_q <= ext_q ? F_EXT : F_PCI0;
              F_EXT: fld_q <= F_PCI0;
              F_PCI0: fld_q <= (!single_q && first_q) ? F_PCI1 : (sent_q != pay_q ? F_DATA : F_PAD);
              F_PCI1: fld_q <= F_DATA;
              F_DATA: fld_q <= data_end ? F_PAD : F_DATA;
              default: fld_q <= F_PAD;
            endcase
          end
        end
        S_TP_WAIT: if (NET_FC_CTS)
          st_q <= S_TP_FRAME;
        S_REPORT: st_q <= S_IDLE;
        default: st_q <= S_IDLE;
      endcase
    end
  end

  // byte and frame counters
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      idx_q <= 13'h0;
      rep_q <= 2'h0;
      ib_q <= 2'h0;
      pos_q <= 4'h0;
      sent_q <= 13'h0;
      sn_q <= 4'h1;
      first_q <= 1'b1;
    end else begin
      if (st_q == S_IDLE) begin
        idx_q <= 13'h0;
        rep_q <= 2'h0;
      end else if (in_x)
        idx_q <= idx_q + 13'h1;
      if (st_q == S_PWM_SEND && out_x)
        rep_q <= rep_q + 2'h1;
      if (st_q == S_TP_ID) begin
        ib_q <= 2'h0;
        pos_q <= 4'h0;
        sent_q <= 13'h0;
        sn_q <= 4'h1;
        first_q <= 1'b1;
      end else if (st_q == S_TP_FRAME && out_x) begin
        if (fld_q == F_ID)
          ib_q <= ib_q + 2'h1;
        else
          pos_q <= f_end ? 4'h0 : pos_q + 4'h1;
        if (fld_q == F_DATA)
          sent_q <= sent_q + 13'h1;
        if (f_end) begin
          first_q <= 1'b0;
          if (!first_q)
            sn_q <= sn_q + 4'h1;
        end
      end
    end
  end

  // header and held bytes
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      proto_q <= 32'h0;
      cnt_q <= 13'h0;
      err_q <= 1'b0;
      ext_q <= 1'b0;
      pad_q <= 1'b0;
      long_q <= 1'b0;
      pay_q <= 13'h0;
      single_q <= 1'b0;
      hold_q <= '{default: 8'h00};
      idb_q <= '{default: 8'h00};
    end else begin
      if (st_q == S_IDLE && TX_HDR_VALID) begin
        proto_q <= TX_PROTOCOL;
        cnt_q <= TX_COUNT[12:0];
        err_q <= !hdr_ok;
        ext_q <= TX_FLAGS[vmfc_pkg::FLAG_EXT_ADDR] && TX_COUNT > vmfc_pkg::LEN_ISOTP_MIN;
        pad_q <= TX_FLAGS[vmfc_pkg::FLAG_ZERO_PAD];
        long_q <= TX_FLAGS[vmfc_pkg::FLAG_LONG_ID];
      end
      if (st_q == S_PWM_HOLD && in_x) begin
        hold_q[idx_q[1:0]] <= TX_BYTE;
        if (idx_q == vmfc_pkg::PWM_SRC_POS && TX_BYTE != NODE_ID)
          err_q <= 1'b1;
      end
      if (st_q == S_TP_ID && in_x) begin
        idb_q[idx_q[2:0]] <= TX_BYTE;
        if (idx_q == hlast) begin
          pay_q <= cnt_q - hlast - 13'h1;
          single_q <= cnt_q - hlast - 13'h1 <= (ext_q ? vmfc_pkg::SF_MAX_EXT : vmfc_pkg::SF_MAX);
        end
      end
    end
  end
endmodule : vmfc_top

// [src/vmfc_pkg.sv]
package vmfc_pkg;

  // protocol selector codes seen on the record header
  localparam logic [31:0] PROTO_VPW = 32'h0000_0001;
  localparam logic [31:0] PROTO_PWM = 32'h0000_0002;
  localparam logic [31:0] PROTO_K9141 = 32'h0000_0003;
  localparam logic [31:0] PROTO_KWP = 32'h0000_0004;
  localparam logic [31:0] PROTO_CAN = 32'h0000_0005;
  localparam logic [31:0] PROTO_ISOTP = 32'h0000_0006;
  localparam logic [31:0] PROTO_SCI = 32'h0000_0007;

  // byte count limits per protocol
  localparam logic [31:0] LEN_CAN_MIN = 32'h4;
  localparam logic [31:0] LEN_CAN_MAX = 32'hC;
  localparam logic [31:0] LEN_ISOTP_MIN = 32'h4;
  localparam logic [31:0] LEN_ISOTP_MAX = 32'h1005;
  localparam logic [31:0] LEN_PWM_MIN = 32'h3;
  localparam logic [31:0] LEN_PWM_MAX = 32'hA;
  localparam logic [31:0] LEN_VPW_MAX = 32'h1020;
  localparam logic [31:0] LEN_K9141_MAX = 32'h105;
  localparam logic [31:0] LEN_KWP_MIN = 32'h4;
  localparam logic [31:0] LEN_KWP_MAX = 32'h105;
  localparam logic [31:0] LEN_SCI_MAX = 32'h100;

  // bit positions in the transmit flag and receive status words
  localparam int FLAG_LONG_ID = 8;
  localparam int FLAG_EXT_ADDR = 7;
  localparam int FLAG_ZERO_PAD = 6;
  localparam int STAT_LONG_ID = 8;

  // record layout
  localparam logic [12:0] ID_LAST = 13'h3;
  localparam logic [12:0] ID_EXT_LAST = 13'h4;
  localparam logic [12:0] PWM_SRC_POS = 13'h2;
  localparam logic [12:0] PWM_HDR = 13'h3;
  localparam logic [3:0] CAN_LAST_POS = 4'h7;
  localparam logic [12:0] SF_MAX = 13'h7;
  localparam logic [12:0] SF_MAX_EXT = 13'h6;

  // segmentation control nibbles
  localparam logic [3:0] PCI_SF = 4'h0;
  localparam logic [3:0] PCI_FF = 4'h1;
  localparam logic [3:0] PCI_CF = 4'h2;

  // timing and reset values
  localparam int CLK_NS = 10;
  localparam int TICK_NS = 1000;
  localparam int US_CYCLES = TICK_NS / CLK_NS;
  localparam logic [31:0] RST_TIME = 32'h0;

  // byte count check: only the listed limits refuse a record
  function automatic logic len_ok(input logic [31:0] proto, input logic [31:0] cnt);
    case (proto)
      PROTO_CAN: len_ok = cnt >= LEN_CAN_MIN && cnt <= LEN_CAN_MAX;
      PROTO_ISOTP: len_ok = cnt >= LEN_ISOTP_MIN && cnt <= LEN_ISOTP_MAX;
      PROTO_PWM: len_ok = cnt >= LEN_PWM_MIN && cnt <= LEN_PWM_MAX;
      PROTO_VPW: len_ok = cnt != 32'h0 && cnt <= LEN_VPW_MAX;
      PROTO_K9141: len_ok = cnt != 32'h0 && cnt <= LEN_K9141_MAX;
      PROTO_KWP: len_ok = cnt >= LEN_KWP_MIN && cnt <= LEN_KWP_MAX;
      PROTO_SCI: len_ok = cnt != 32'h0 && cnt <= LEN_SCI_MAX;
      default: len_ok = cnt <= LEN_VPW_MAX;
    endcase
  endfunction : len_ok

endpackage : vmfc_pkg

// [src/vmfc_time_if.sv]
// free-running microsecond time shared by the block's parts
interface vmfc_time_if;
  logic [31:0] now_us;
  logic tick;
  modport src (output now_us, output tick);
  modport dst (input now_us, input tick);
endinterface : vmfc_time_if

// [src/vmfc_ustimer.sv]
module vmfc_ustimer #(
  parameter int CYCLES = vmfc_pkg::US_CYCLES
) (
  input wire logic clk, // system clock
  input wire logic rst, // synchronous reset
  vmfc_time_if.src tm // time out
);
  if (CYCLES < 1 || CYCLES > 65535) begin : g_chk
    $error("CYCLES out of range");
  end

  logic [15:0] div_q;
  logic [31:0] now_q;
  logic tick;

  // one-cycle enable per microsecond
  assign tick = div_q == 16'(CYCLES - 1);
  assign tm.tick = tick;
  assign tm.now_us = now_q;

  // divider; the counter wraps silently after 2^32 us
  always_ff @(posedge clk) begin
    if (rst) begin
      div_q <= 16'h0;
      now_q <= vmfc_pkg::RST_TIME;
    end else if (tick) begin
      div_q <= 16'h0;
      now_q <= now_q + 32'h1;
    end else begin
      div_q <= div_q + 16'h1;
    end
  end
endmodule : vmfc_ustimer

// [src/vmfc_rx.sv]
module vmfc_rx (
  input wire logic clk, // system clock
  input wire logic rst, // synchronous reset
  input wire logic [31:0] proto, // receive protocol selector
  input wire logic ext_addr, // extended address present
  input wire logic in_v, // network byte valid
  input wire logic [7:0] in_d, // network byte
  input wire logic in_last, // last byte of frame
  input wire logic in_trl, // byte is trailer
  input wire logic in_long, // 29-bit identifier frame
  vmfc_time_if.dst tm, // microsecond time
  output logic out_v, // record byte valid
  output logic [7:0] out_d, // record byte
  output logic done, // record complete
  output logic [12:0] count, // record byte count
  output logic [12:0] trl_idx, // trailer start index
  output logic [31:0] stamp, // reception time
  output logic [31:0] status // receive status word
);
  logic [12:0] pos_q, n_q, tix_q, n_next, pci_pos;
  logic [3:0] pci_q;
  logic seen_q, drop, keep;
  logic [31:0] t_q;

  // the segmentation byte(s) never reach the host
  assign pci_pos = ext_addr ? vmfc_pkg::ID_EXT_LAST + 13'h1 : vmfc_pkg::ID_LAST + 13'h1;
  assign drop = proto == vmfc_pkg::PROTO_ISOTP &&
                (pos_q == pci_pos || (pos_q == pci_pos + 13'h1 && pci_q == vmfc_pkg::PCI_FF));
  assign keep = in_v && !drop;
  assign n_next = n_q + {12'h0, keep};

  // frame position, pci type, trailer tracking
  always_ff @(posedge clk) begin
    if (rst) begin
      pos_q <= 13'h0;
      n_q <= 13'h0;
      tix_q <= 13'h0;
      seen_q <= 1'b0;
      pci_q <= 4'h0;
      t_q <= vmfc_pkg::RST_TIME;
    end else if (in_v) begin
      pos_q <= in_last ? 13'h0 : pos_q + 13'h1;
      n_q <= in_last ? 13'h0 : n_next;
      if (pos_q == pci_pos)
        pci_q <= in_d[7:4];
      if (pos_q == 13'h0)
        t_q <= tm.now_us;
      if (in_last)
        seen_q <= 1'b0;
      else if (keep && in_trl && !seen_q) begin
        seen_q <= 1'b1;
        tix_q <= n_q;
      end
    end
  end

  // byte stream out, one cycle behind the network
  always_ff @(posedge clk) begin
    if (rst) begin
      out_v <= 1'b0;
      out_d <= 8'h00;
      done <= 1'b0;
    end else begin
      out_v <= keep;
      out_d <= in_d;
      done <= in_v && in_last;
    end
  end

  // record summary, updated with the last byte
  always_ff @(posedge clk) begin
    if (rst) begin
      count <= 13'h0;
      trl_idx <= 13'h0;
      stamp <= vmfc_pkg::RST_TIME;
      status <= 32'h0;
    end else if (in_v && in_last) begin
      count <= n_next;
      stamp <= pos_q == 13'h0 ? tm.now_us : t_q;
      status <= 32'h0;
      status[vmfc_pkg::STAT_LONG_ID] <= in_long;
      if (proto == vmfc_pkg::PROTO_K9141 || proto == vmfc_pkg::PROTO_KWP)
        trl_idx <= n_next - 13'h1;
      else if (proto == vmfc_pkg::PROTO_SCI)
        trl_idx <= n_next;
      else if (seen_q)
        trl_idx <= tix_q;
      else
        trl_idx <= keep && in_trl ? n_q : n_next;
    end
  end
endmodule : vmfc_rx

// [verification/vmfc_top_monitor.sv]
module vmfc_top_monitor (
  input wire logic MCLK, // clock
  input wire logic SRST, // reset
  input wire logic TX_HDR_VALID, // header offered
  input wire logic TX_HDR_READY, // header taken
  input wire logic [31:0] TX_PROTOCOL, // selector
  input wire logic [31:0] TX_COUNT, // byte count
  input wire logic TX_DONE, // done pulse
  input wire logic TX_ERROR, // refusal pulse
  input wire logic NET_TX_VALID, // network byte
  input wire logic [31:0] RX_PROTOCOL, // rx selector
  input wire logic NET_RX_VALID, // rx byte
  input wire logic [7:0] NET_RX_DATA, // rx data
  input wire logic NET_RX_LAST, // rx last
  input wire logic REC_VALID, // record byte
  input wire logic [7:0] REC_DATA, // record data
  input wire logic REC_DONE // record done
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (SRST);
  // a header is taken on this edge; p and c are what it carries
  wire logic tk = TX_HDR_VALID && TX_HDR_READY;
  wire logic [31:0] p = TX_PROTOCOL;
  wire logic [31:0] c = TX_COUNT;
  // a refused header ends next cycle with nothing put on the network
  a_can_len: assert property (
    tk && p == 32'h5 && (c < 32'h4 || c > 32'hC) |=> TX_DONE && TX_ERROR && !NET_TX_VALID)
    else $error("raw count not refused");
  a_isotp_len: assert property (
    tk && p == 32'h6 && (c < 32'h4 || c > 32'h1005) |=> TX_DONE && TX_ERROR)
    else $error("segmented count not refused");
  a_pwm_len: assert property (
    tk && p == 32'h2 && (c < 32'h3 || c > 32'hA) |=> TX_DONE && TX_ERROR)
    else $error("pwm count not refused");
  a_vpw_len: assert property (
    tk && p == 32'h1 && (c == 32'h0 || c > 32'h1020) |=> TX_DONE && TX_ERROR)
    else $error("vpw count not refused");
  a_k9141_len: assert property (
    tk && p == 32'h3 && (c == 32'h0 || c > 32'h105) |=> TX_DONE && TX_ERROR)
    else $error("9141 count not refused");
  a_kwp_len: assert property (
    tk && p == 32'h4 && (c < 32'h4 || c > 32'h105) |=> TX_DONE && TX_ERROR)
    else $error("kwp count not refused");
  a_sci_len: assert property (
    tk && p == 32'h7 && (c == 32'h0 || c > 32'h100) |=> TX_DONE && TX_ERROR)
    else $error("sci count not refused");
  a_err_done: assert property (
    TX_ERROR |-> TX_DONE && !NET_TX_VALID && !$past(NET_TX_VALID)) else $error("error without done or with output");
  // raw frames reach the record untouched, one cycle later
  a_rx_pass: assert property (
    NET_RX_VALID && RX_PROTOCOL == 32'h5 |=> REC_VALID && REC_DATA == $past(NET_RX_DATA))
    else $error("raw rx byte altered");
  a_rx_done: assert property (
    NET_RX_VALID && NET_RX_LAST |=> REC_DONE) else $error("record not closed");
endmodule : vmfc_top_monitor

bind vmfc_top vmfc_top_monitor u_mon (.MCLK, .SRST, .TX_HDR_VALID, .TX_HDR_READY, .TX_PROTOCOL,
  .TX_COUNT, .TX_DONE, .TX_ERROR, .NET_TX_VALID, .RX_PROTOCOL, .NET_RX_VALID, .NET_RX_DATA,
  .NET_RX_LAST, .REC_VALID, .REC_DATA, .REC_DONE);

// [verification/vmfc_host_model.sv]
module vmfc_host_model (
  input wire logic clk, // system clock
  input wire logic go, // start one record
  input wire logic [31:0] cnt, // bytes to offer
  input wire logic [7:0] b2, // byte at index 2
  output logic hdr_v, // header offered
  input wire logic hdr_r, // header taken
  output logic byte_v, // byte offered
  input wire logic byte_r, // byte taken
  output logic [7:0] byte_o // record byte
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    hdr_v = 1'b0;
    byte_v = 1'b0;
    byte_o = 8'h0;
  end
  // header, then cnt body bytes and no trailer; each held until taken
  always begin
    @(posedge clk);
    if (go) begin
      #1 hdr_v = 1'b1;
      #1;
      while (!hdr_r) begin
        @(posedge clk);
        #2;
      end
      @(posedge clk);
      #1 hdr_v = 1'b0;
      for (int i = 0; i < cnt; i++) begin
        byte_v = 1'b1;
        byte_o = (i == 2) ? b2 : i[7:0] ^ 8'h5A;
        #1;
        while (!byte_r) begin
          @(posedge clk);
          #2;
        end
        @(posedge clk);
        #1;
      end
      byte_v = 1'b0;
      byte_o = ~byte_o; // released: never leave a stale byte showing
    end
  end
endmodule : vmfc_host_model

// [verification/tb_vehicle_msg_format_checker.sv]
module tb_vehicle_msg_format_checker;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [3:0] p; logic [31:0] n; logic e;} vmfc_row_t;
  typedef struct {logic [3:0] p; logic [7:0] n; logic [7:0] t; logic l; logic [12:0] c; logic [12:0] x;} vmfc_rx_t;
  logic MCLK, SRST, TX_HDR_VALID, TX_HDR_READY, TX_BYTE_VALID, TX_BYTE_READY, TX_DONE, TX_ERROR;
  logic NET_TX_VALID, NET_TX_READY, NET_TX_LAST, NET_TX_LONG_ID, NET_FC_CTS, RX_EXT_ADDR;
  logic NET_RX_VALID, NET_RX_LAST, NET_RX_TRAILER, NET_RX_LONG_ID, REC_VALID, REC_DONE;
  logic [7:0] NODE_ID, TX_BYTE, NET_TX_DATA, NET_RX_DATA, REC_DATA, b2;
  logic [31:0] TX_PROTOCOL, TX_FLAGS, TX_COUNT, RX_PROTOCOL, REC_TIMESTAMP, REC_STATUS, cnt, st;
  logic [12:0] REC_COUNT, REC_TRAILER_IDX;
  logic [7:0] cap [64];
  logic [1:0] ph = 2'h0;
  logic [7:0] rcap [64];
  logic go, long_seen;
  int n_mismatch = 0;
  int num_checks = 0;
  int cyc = 0;
  int n_net = 0;
  int n_rec = 0;
  int last_pos = 0;
  // count boundaries of every protocol, then one unknown selector
  vmfc_row_t rows [25] = '{'{5, 3, 1}, '{5, 4, 0}, '{5, 'hC, 0}, '{5, 'hD, 1}, '{6, 3, 1}, '{6, 'h1005, 0},
    '{6, 'h1006, 1}, '{2, 2, 1}, '{2, 3, 0}, '{2, 'hA, 0}, '{2, 'hB, 1}, '{1, 0, 1}, '{1, 'h1020, 0},
    '{1, 'h1021, 1}, '{3, 0, 1}, '{3, 'h105, 0}, '{3, 'h106, 1}, '{4, 3, 1}, '{4, 4, 0}, '{4, 'h105, 0},
    '{4, 'h106, 1}, '{7, 0, 1}, '{7, 'h100, 0}, '{7, 'h101, 1}, '{9, 0, 0}};
  vmfc_rx_t rxr [5] = '{'{5, 6, 0, 1, 6, 6}, '{1, 5, 2, 0, 5, 3}, '{3, 4, 1, 0, 4, 3}, '{7, 4, 0, 0, 4, 4},
    '{6, 7, 0, 0, 6, 6}};

  vmfc_top #(.US_CYCLES(2)) dut (.MCLK, .SRST, .NODE_ID, .TX_HDR_VALID, .TX_HDR_READY, .TX_PROTOCOL,
    .TX_FLAGS, .TX_COUNT, .TX_BYTE_VALID, .TX_BYTE_READY, .TX_BYTE, .TX_DONE, .TX_ERROR, .NET_TX_VALID,
    .NET_TX_READY, .NET_TX_DATA, .NET_TX_LAST, .NET_TX_LONG_ID, .NET_FC_CTS, .RX_PROTOCOL, .RX_EXT_ADDR,
    .NET_RX_VALID, .NET_RX_DATA, .NET_RX_LAST, .NET_RX_TRAILER, .NET_RX_LONG_ID, .REC_VALID, .REC_DATA,
    .REC_DONE, .REC_COUNT, .REC_TRAILER_IDX, .REC_TIMESTAMP, .REC_STATUS);
  vmfc_host_model host (.clk(MCLK), .go(go), .cnt(cnt), .b2(b2), .hdr_v(TX_HDR_VALID),
    .hdr_r(TX_HDR_READY), .byte_v(TX_BYTE_VALID), .byte_r(TX_BYTE_READY), .byte_o(TX_BYTE));

  initial begin
    MCLK = 1'b0;
    forever #5 MCLK = ~MCLK;
  end
  // network side stalls one cycle in three and grants clear-to-send after each frame
  always @(posedge MCLK) begin
    ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
    NET_TX_READY <= (ph != 2'h1);
    NET_FC_CTS <= NET_TX_VALID && NET_TX_READY && NET_TX_LAST;
    if (NET_TX_VALID && NET_TX_READY) begin
      if (n_net < 64) cap[n_net] <= NET_TX_DATA;
      if (NET_TX_LAST) last_pos <= n_net; // frame end position
      n_net <= n_net + 1;
      long_seen <= NET_TX_LONG_ID;
    end
  end
  // record bytes as the host would receive them
  always @(posedge MCLK) begin
    if (REC_VALID) begin
      if (n_rec < 64) rcap[n_rec] <= REC_DATA;
      n_rec <= n_rec + 1;
    end
  end
  // hang guard, well above the longest record sequence
  always @(posedge MCLK) begin
    cyc++;
    if (cyc == 60000) begin
      n_mismatch++;
      close_out();
    end
  end

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task close_out;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : close_out

  // one record from header to done; a refused one offers no body bytes unless bad is set
  task run_tx(input logic [3:0] p, input logic [31:0] f, input logic [31:0] n, input logic bad, input logic e);
    int k;
    TX_PROTOCOL = {28'h0, p};
    TX_FLAGS = f;
    TX_COUNT = n;
    n_net = 0;
    b2 = (p == 4'h2) ? (NODE_ID ^ {7'h0, bad}) : 8'h58;
    cnt = (e && !bad) ? 32'h0 : n;
    go = 1'b1;
    @(posedge MCLK) #1;
    go = 1'b0;
    k = 0;
    while (TX_DONE !== 1'b1 && k < 20000) begin
      @(posedge MCLK) #1;
      k++;
    end
    chk("done", 32'h1, {31'h0, TX_DONE});
    chk("error", {31'h0, e}, {31'h0, TX_ERROR});
    @(posedge MCLK) #1;
  endtask : run_tx

  initial begin
    {SRST, go, RX_EXT_ADDR, NET_RX_VALID, NET_RX_LAST} = 5'h10;
    {NET_RX_TRAILER, NET_RX_LONG_ID, NET_RX_DATA, cnt, b2} = '0;
    {TX_PROTOCOL, TX_FLAGS, TX_COUNT, RX_PROTOCOL} = '0;
    NODE_ID = 8'h47;
    repeat (16) @(posedge MCLK);
    #1 SRST = 1'b0;
    chk("hdr ready", 32'h1, {31'h0, TX_HDR_READY});
    chk("rec done", 32'h0, {31'h0, REC_DONE});
    foreach (rows[i]) begin
      run_tx(rows[i].p, 32'h0, rows[i].n, 1'b0, rows[i].e);
      if (rows[i].e || rows[i].p == 4'h5 || rows[i].p == 4'h2) chk("net count", rows[i].e ? 0 : rows[i].n, n_net);
    end
    // raw frame leaves byte for byte as offered
    run_tx(4'h5, 32'h0, 32'hC, 1'b0, 1'b0);
    for (int i = 0; i < 12; i++) chk("can byte", {24'h0, i[7:0] ^ 8'h5A}, {24'h0, cap[i]});
    run_tx(4'h2, 32'h0, 32'h5, 1'b1, 1'b1);
    chk("net count", 32'h0, n_net);
    // long id, extended address and zero fill in one single frame
    run_tx(4'h6, 32'h1C0, 32'h6, 1'b0, 1'b0);
    chk("long id", 32'h1, {31'h0, long_seen});
    chk("pad count", 32'hC, n_net);
    chk("frame end", 32'hB, last_pos);
    chk("ext addr", 32'h5E, {24'h0, cap[4]});
    chk("pci", 32'h1, {24'h0, cap[5]});
    chk("data", 32'h5F, {24'h0, cap[6]});
    for (int i = 7; i < 12; i++) chk("pad", 32'h0, {24'h0, cap[i]});
    run_tx(4'h6, 32'h0, 32'h6, 1'b0, 1'b0);
    chk("sf count", 32'h7, n_net);
    chk("sf end", 32'h6, last_pos);
    chk("sf pci", 32'h2, {24'h0, cap[4]});
    chk("id byte", 32'h59, {24'h0, cap[3]});
    // received frames, twenty cycles apart, so ten microseconds apart
    foreach (rxr[i]) begin
      RX_PROTOCOL = {28'h0, rxr[i].p};
      for (int j = 0; j < rxr[i].n; j++) begin
        NET_RX_VALID = 1'b1;
        NET_RX_DATA = j[7:0] ^ 8'h3C;
        NET_RX_LAST = (j == rxr[i].n - 1);
        NET_RX_TRAILER = (j >= rxr[i].n - rxr[i].t);
        NET_RX_LONG_ID = rxr[i].l;
        @(posedge MCLK) #1;
      end
      NET_RX_VALID = 1'b0;
      chk("rec done", 32'h1, {31'h0, REC_DONE});
      chk("rec count", {19'h0, rxr[i].c}, {19'h0, REC_COUNT});
      chk("trailer idx", {19'h0, rxr[i].x}, {19'h0, REC_TRAILER_IDX});
      chk("status", {23'h0, rxr[i].l, 8'h0}, REC_STATUS);
      if (i > 0) chk("stamp step", st + 32'hA, REC_TIMESTAMP);
      st = REC_TIMESTAMP;
      repeat (20 - rxr[i].n) @(posedge MCLK);
      #1;
      // by now every record byte of this frame has been seen
      chk("rec bytes", {19'h0, rxr[i].c}, n_rec);
      if (rxr[i].c > 13'h4) chk("rec byte 4", {24'h0, (rxr[i].p == 4'h6 ? 8'h05 : 8'h04) ^ 8'h3C}, {24'h0, rcap[4]});
      n_rec = 0;
    end
    // mid-run reset clears the record summary; a header is taken right after release
    SRST = 1'b1;
    @(posedge MCLK) #1;
    SRST = 1'b0;
    chk("rst count", 32'h0, {19'h0, REC_COUNT});
    chk("rst trailer", 32'h0, {19'h0, REC_TRAILER_IDX});
    chk("rst stamp", 32'h0, REC_TIMESTAMP);
    run_tx(4'h5, 32'h100, 32'h4, 1'b0, 1'b0);
    chk("net count", 32'h4, n_net);
    chk("long id", 32'h1, {31'h0, long_seen});
    close_out();
  end
endmodule : tb_vehicle_msg_format_checker
